// >>> hw/wdr_defines.vh
// constants for the watchdog and reset control block
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH
`define WDR_ADDR_W 2
`define WDR_ADDR_CONTROL 2'h0
`define WDR_ADDR_STATUS 2'h1
`define WDR_ADDR_PORTS 2'h2
`define WDR_CTRL_RESET 8'h7a
`define WDR_KEY_DISABLE 4'ha
`define WDR_KEY_LSB 0
`define WDR_KEY_MSB 3
`define WDR_SEL_LSB 4
`define WDR_SEL_MSB 6
`define WDR_IDLE_KEEP_BIT 7
`define WDR_BASE_PERIOD 16'h0100
`define WDR_CLK_HZ 25000000
`define WDR_RESET_DELAY_MS 100
`define WDR_RESET_DELAY_CYC ((`WDR_CLK_HZ / 1000) * `WDR_RESET_DELAY_MS)
`define WDR_SST_RC 16'h0010
`define WDR_SST_XTAL 16'h0400
`define WDR_SST_SLOW 16'h0002
`define WDR_SRC_CRYSTAL 2'h0
`define WDR_SRC_FAST_RC 2'h1
`define WDR_SRC_EXT_RC 2'h2
`define WDR_SRC_SLOW_RC 2'h3
`define WDR_BROWNOUT_MIN_CYC 8'h19
`define WDR_PORT_RESET 8'hff
`endif

// >>> hw/wdr_glitch_filter.v
// qualifies a level that must persist longer than a minimum count
`default_nettype none
module wdr_glitch_filter #(
    parameter [7:0] MIN_CYC = 8'h10
) (
    input wire clock_i,     // core clock
    input wire resetn_i,    // async reset, active low
    input wire level_i,     // raw condition
    output reg qual_o       // held once condition outlasts MIN_CYC
);
    reg [7:0] cnt;
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 8'h00;
            qual_o <= 1'b0;
        end else if (!level_i) begin
            cnt <= 8'h00;
            qual_o <= 1'b0;
        end else if (cnt > MIN_CYC) begin
            qual_o <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // wdr_glitch_filter
`default_nettype wire

// >>> hw/wdr_pulse_div.v
// one-cycle enable pulse every N enabled input ticks
`default_nettype none
module wdr_pulse_div #(
    parameter N = 4
) (
    input wire clock_i,     // core clock
    input wire resetn_i,    // async reset, active low
    input wire tick_i,      // input tick enable
    input wire clear_i,     // restart the division
    output reg pulse_o      // divided tick
);
    reg [15:0] cnt;
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 16'h0000;
            pulse_o <= 1'b0;
        end else if (clear_i) begin
            cnt <= 16'h0000;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                if (cnt == N[15:0] - 16'h0001) begin
                    cnt <= 16'h0000;
                    pulse_o <= 1'b1;
                end else begin
                    cnt <= cnt + 16'h0001;
                end
            end
        end
    end
endmodule // wdr_pulse_div
`default_nettype wire

// >>> hw/wdr_top.v
// watchdog timer and reset source control
// Summary of operation
// [RULE_01] select code sets period 256 doubling to 32768
// [RULE_02] disabled only by option plus key 1010
// [RULE_03] key holds 1010 after power-on
// [RULE_04] software should write key 0101 when used
// [RULE_05] disabled watchdog makes its commands no-ops
// [RULE_06] run-mode overflow is full reset, expiry set
// [RULE_07] sleep overflow sets expiry, clears pc/sp only
// [RULE_08] pin low, clear commands, halt clear count
// [RULE_09] option picks single or paired clear
// [RULE_10] alternating half commands each clear
// [RULE_11] repeated same half command does nothing
// [RULE_12] bit 7 keeps core clock in idle
// [RULE_13] divided core source stops when clock stops
// [RULE_14] power-on sets port registers high, pc zero
// [RULE_15] full resets wait 100ms before execution
// [RULE_16] reset pin shares port bit, option enabled
// [RULE_17] low pin resets device, pc restarts zero
// [RULE_18] low-supply reset is full, option enabled
// [RULE_19] short low-supply glitches are ignored
// [RULE_20] wake-up delay depends on oscillator source
// [RULE_21] source slow rc or core/4, divided 2^8..2^15
// [RULE_22] expiry and powerdown flags per reset type
// [RULE_23] count up from zero, overflow at period
// [RULE_24] control register fully read/write
//
// Decided for this implementation: the address map and the address-and-strobe port.
`default_nettype none
`include "wdr_defines.vh"
module wdr_top #(
    parameter [31:0] RESET_DELAY_CYC = `WDR_RESET_DELAY_CYC
) (
    input wire clock_i,                 // core clock, 25 MHz
    input wire resetn_i,                // power-on reset, active low
    input wire [`WDR_ADDR_W-1:0] addr_i, // register address
    input wire [7:0] wdata_i,           // write data
    input wire wr_i,                    // write strobe
    input wire rd_i,                    // read strobe
    output reg [7:0] rdata_o,           // read data, cycle after strobe
    input wire opt_dog_enable_i,        // option: watchdog forced on
    input wire opt_paired_clear_i,      // option: paired clear mode
    input wire opt_src_core_i,          // option: core/4 source, else slow rc
    input wire opt_ext_reset_en_i,      // option: port bit is reset pin
    input wire opt_low_supply_en_i,     // option: low-supply reset enabled
    input wire [1:0] opt_osc_src_i,     // option: system oscillator kind
    input wire slow_rc_tick_i,          // slow internal rc tick enable
    input wire shared_port_bit_i,       // external_rst_pin level, active low
    input wire low_supply_i,            // low-supply condition, active high
    input wire single_clear_cmd_i,      // core executed single clear
    input wire clear_half_a_i,          // core executed half clear a
    input wire clear_half_b_i,          // core executed half clear b
    input wire halt_cmd_i,              // core executed halt
    input wire idle_req_i,              // halt enters idle, else sleep
    output reg core_reset_o,            // full device reset to core
    output reg pc_sp_clear_o,           // clear pc and sp only, pulse
    output reg run_o,                   // core may execute
    output reg core_clock_en_o,         // core clock enable
    output reg dog_expiry_flag_o,       // expiry flag
    output reg powerdown_flag_o,        // powerdown flag
    output reg [7:0] port_data_o,       // port data register
    output reg [7:0] port_dir_o         // port direction register
);
    localparam [3:0] ST_DELAY = 4'h1;
    localparam [3:0] ST_RUN = 4'h2;
    localparam [3:0] ST_HALT = 4'h4;
    localparam [3:0] ST_WAKE = 4'h8;

    reg [3:0] state;
    reg [7:0] watchdog_control;
    reg [31:0] delay_cnt;
    reg [15:0] dog_cnt;
    reg last_half_b;
    reg half_seen;
    reg in_idle;
    reg [15:0] next_period;
    reg [15:0] sst_len;
    wire dog_on;
    wire pin_rst;
    wire brown_rst;
    wire full_rst;
    wire core4_pulse;
    wire dog_tick;
    wire clk_running;
    wire cmd_clear;
    wire dog_clear;
    wire overflow;
    wire asleep;

    assign dog_on = opt_dog_enable_i ||
        (watchdog_control[`WDR_KEY_MSB:`WDR_KEY_LSB] != `WDR_KEY_DISABLE); // [RULE_02]
    assign pin_rst = opt_ext_reset_en_i && !shared_port_bit_i; // [RULE_16] [RULE_17]
    assign full_rst = pin_rst || brown_rst; // [RULE_18]
    assign asleep = (state == ST_HALT);
    // core clock stops in sleep, and in idle unless kept
    assign clk_running = !asleep ||
        (in_idle && watchdog_control[`WDR_IDLE_KEEP_BIT]); // [RULE_12] [RULE_13]

    wdr_glitch_filter #(
        .MIN_CYC(`WDR_BROWNOUT_MIN_CYC)
    ) u_brown (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .level_i(low_supply_i && opt_low_supply_en_i),
        .qual_o(brown_rst)
    ); // [RULE_19]

    wdr_pulse_div #(
        .N(4)
    ) u_core4 (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .tick_i(clk_running),
        .clear_i(1'b0),
        .pulse_o(core4_pulse)
    ); // [RULE_13]

    assign dog_tick = opt_src_core_i ? core4_pulse : slow_rc_tick_i; // [RULE_21]

    // paired mode: a half clears when it is the first since reset or follows the other kind
    assign cmd_clear = dog_on && (state == ST_RUN) && (opt_paired_clear_i ?
        ((clear_half_a_i && (!half_seen || last_half_b)) ||
         (clear_half_b_i && (!half_seen || !last_half_b))) :
        single_clear_cmd_i); // [RULE_05] [RULE_09] [RULE_10] [RULE_11]
    assign dog_clear = cmd_clear || (halt_cmd_i && state == ST_RUN) || pin_rst; // [RULE_08]
    assign overflow = dog_on && (dog_cnt >= next_period - 16'h0001) && dog_tick; // [RULE_23]

    always @* begin
        next_period = `WDR_BASE_PERIOD << watchdog_control[`WDR_SEL_MSB:`WDR_SEL_LSB]; // [RULE_01]
        case (opt_osc_src_i)
            `WDR_SRC_CRYSTAL: sst_len = `WDR_SST_XTAL;
            `WDR_SRC_SLOW_RC: sst_len = `WDR_SST_SLOW;
            default: sst_len = `WDR_SST_RC;
        endcase // [RULE_20]
    end

    // half-clear history
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_seen <= 1'b0;
            last_half_b <= 1'b0;
        end else if (full_rst || (overflow && state == ST_RUN)) begin
            half_seen <= 1'b0; // [RULE_06]
        end else if (dog_on && state == ST_RUN && opt_paired_clear_i) begin
            if (clear_half_a_i) begin
                half_seen <= 1'b1;
                last_half_b <= 1'b0;
            end else if (clear_half_b_i) begin
                half_seen <= 1'b1;
                last_half_b <= 1'b1;
            end
        end
    end

    // watchdog counter
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dog_cnt <= 16'h0000;
        end else if (dog_clear || overflow || !dog_on || state == ST_DELAY) begin
            dog_cnt <= 16'h0000; // [RULE_08] [RULE_23]
        end else if (dog_tick) begin
            dog_cnt <= dog_cnt + 16'h0001; // [RULE_23]
        end
    end

    // control register and readback
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            watchdog_control <= `WDR_CTRL_RESET; // [RULE_03] [RULE_24]
            rdata_o <= 8'h00;
        end else begin
            // full resets and a run-mode overflow reload the register; a sleep overflow and the wake delay keep it
            if (full_rst || (overflow && state == ST_RUN)) begin
                watchdog_control <= `WDR_CTRL_RESET;
            end else if (wr_i && addr_i == `WDR_ADDR_CONTROL) begin
                watchdog_control <= wdata_i; // [RULE_24]
            end
            rdata_o <= 8'h00;
            if (rd_i) begin
                case (addr_i)
                    `WDR_ADDR_CONTROL: rdata_o <= watchdog_control;
                    `WDR_ADDR_STATUS: rdata_o <= {3'h0, dog_on, run_o, asleep,
                        powerdown_flag_o, dog_expiry_flag_o};
                    `WDR_ADDR_PORTS: rdata_o <= port_dir_o;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // sequencer and flags
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_DELAY;
            delay_cnt <= 32'h0;
            in_idle <= 1'b0;
            core_reset_o <= 1'b1;
            pc_sp_clear_o <= 1'b0;
            run_o <= 1'b0;
            core_clock_en_o <= 1'b1;
            dog_expiry_flag_o <= 1'b0; // [RULE_22]
            powerdown_flag_o <= 1'b0; // [RULE_22]
            port_data_o <= `WDR_PORT_RESET; // [RULE_14]
            port_dir_o <= `WDR_PORT_RESET; // [RULE_14]
        end else begin
            pc_sp_clear_o <= 1'b0;
            core_clock_en_o <= clk_running;
            if (full_rst) begin
                // pin and low-supply leave flags untouched
                state <= ST_DELAY; // [RULE_15] [RULE_17] [RULE_22]
                delay_cnt <= 32'h0;
                core_reset_o <= 1'b1;
                run_o <= 1'b0;
                port_data_o <= `WDR_PORT_RESET;
                port_dir_o <= `WDR_PORT_RESET;
            end else begin
                case (state)
                    ST_DELAY: begin
                        if (delay_cnt >= RESET_DELAY_CYC - 32'h1) begin
                            state <= ST_RUN; // [RULE_15]
                            core_reset_o <= 1'b0;
                            run_o <= 1'b1;
                        end else begin
                            delay_cnt <= delay_cnt + 32'h1;
                        end
                    end
                    ST_RUN: begin
                        if (overflow) begin
                            dog_expiry_flag_o <= 1'b1; // [RULE_06]
                            state <= ST_DELAY; // [RULE_06]
                            delay_cnt <= 32'h0;
                            core_reset_o <= 1'b1;
                            run_o <= 1'b0;
                            port_data_o <= `WDR_PORT_RESET;
                            port_dir_o <= `WDR_PORT_RESET;
                        end else if (halt_cmd_i) begin
                            state <= ST_HALT;
                            in_idle <= idle_req_i;
                            run_o <= 1'b0;
                            powerdown_flag_o <= 1'b1;
                            dog_expiry_flag_o <= 1'b0;
                        end else if (cmd_clear) begin
                            powerdown_flag_o <= 1'b0;
                            dog_expiry_flag_o <= 1'b0;
                        end
                    end
                    ST_HALT: begin
                        if (overflow) begin
                            dog_expiry_flag_o <= 1'b1; // [RULE_07] [RULE_22]
                            pc_sp_clear_o <= 1'b1; // [RULE_07]
                            state <= ST_WAKE;
                            delay_cnt <= 32'h0;
                        end
                    end
                    ST_WAKE: begin
                        if (delay_cnt >= {16'h0, sst_len} - 32'h1) begin
                            state <= ST_RUN; // [RULE_20]
                            run_o <= 1'b1;
                            in_idle <= 1'b0;
                        end else begin
                            delay_cnt <= delay_cnt + 32'h1;
                        end
                    end
                    default: begin
                        state <= ST_DELAY;
                        delay_cnt <= 32'h0;
                    end
                endcase
            end
        end
    end
endmodule // wdr_top
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the watchdog and reset control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, resetn_i, wr_i, rd_i, opt_dog_enable_i, opt_paired_clear_i;
    logic opt_src_core_i, opt_ext_reset_en_i, opt_low_supply_en_i, slow_rc_tick_i;
    logic shared_port_bit_i, low_supply_i, single_clear_cmd_i, clear_half_a_i;
    logic clear_half_b_i, halt_cmd_i, idle_req_i, core_reset_o, pc_sp_clear_o;
    logic run_o, core_clock_en_o, dog_expiry_flag_o, powerdown_flag_o;
    logic [1:0] addr_i, opt_osc_src_i;
    logic [2:0] tick_div = 3'h0;
    logic [7:0] wdata_i, rdata_o, port_data_o, port_dir_o;
    int failures, tests_run, at;
    wdr_top #(.RESET_DELAY_CYC(32'd20)) dut (.clock_i, .resetn_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .opt_dog_enable_i, .opt_paired_clear_i, .opt_src_core_i,
        .opt_ext_reset_en_i, .opt_low_supply_en_i, .opt_osc_src_i, .slow_rc_tick_i,
        .shared_port_bit_i, .low_supply_i, .single_clear_cmd_i, .clear_half_a_i,
        .clear_half_b_i, .halt_cmd_i, .idle_req_i, .core_reset_o, .pc_sp_clear_o,
        .run_o, .core_clock_en_o, .dog_expiry_flag_o, .powerdown_flag_o,
        .port_data_o, .port_dir_o);
    wdr_core_model core (.clock_i, .run_i(run_o), .single_o(single_clear_cmd_i),
        .half_a_o(clear_half_a_i), .half_b_o(clear_half_b_i), .halt_o(halt_cmd_i));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // slow oscillator as one tick every eight core clocks
    always @(posedge clock_i) begin
        tick_div <= tick_div + 3'h1;
        slow_rc_tick_i <= tick_div == 3'h7;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, e);
    endtask
    // first cycle with a reset or wake event, else -1
    task automatic watch(input int n, output int t);
        t = -1;
        for (int i = 0; i < n && t < 0; i++) begin
            @(posedge clock_i);
            #1 if (core_reset_o === 1'b1 || pc_sp_clear_o === 1'b1) t = i;
        end
    endtask
    task automatic wait_run;
        for (int i = 0; i < 3000 && run_o !== 1'b1; i++) @(posedge clock_i);
        chk("run", {7'h0, run_o}, 8'h01);
    endtask
    task automatic pin_low(input logic en);
        @(posedge clock_i);
        opt_ext_reset_en_i <= en;
        shared_port_bit_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        shared_port_bit_i <= 1'b1;
        #1 chk("pin_reset", {7'h0, core_reset_o}, {7'h0, en});
    endtask
    task automatic t_overflow;
        wr(2'h0, 8'h85);
        rd(2'h0, 8'h85);
        rd(2'h3, 8'h00);
        for (int k = 0; k < 3; k++) begin
            watch(600, at);
            chk("cleared", {7'h0, at < 0}, 8'h01);
            core.exec(2'h0);
        end
        watch(1100, at);
        chk("period", {7'h0, at >= 900}, 8'h01);
        chk("expiry", {7'h0, dog_expiry_flag_o}, 8'h01);
        wait_run;
        rd(2'h0, 8'h7a);
    endtask
    task automatic t_pin;
        wr(2'h0, 8'h05);
        pin_low(1'b0);
        pin_low(1'b1);
        chk("expiry_kept", {7'h0, dog_expiry_flag_o}, 8'h01);
        wait_run;
        rd(2'h0, 8'h7a);
    endtask
    task automatic t_disable;
        opt_dog_enable_i <= 1'b0;
        wr(2'h0, 8'h0a);
        core.exec(2'h0);
        watch(1500, at);
        chk("disabled", {7'h0, at < 0}, 8'h01);
        opt_dog_enable_i <= 1'b1;
        watch(1100, at);
        chk("forced_on", {7'h0, at >= 0}, 8'h01);
        wait_run;
    endtask
    task automatic t_paired;
        opt_paired_clear_i <= 1'b1;
        wr(2'h0, 8'h05);
        for (int k = 0; k < 3; k++) begin
            core.exec(2'h1);
            watch(400, at);
        end
        chk("same_half", {7'h0, at >= 0}, 8'h01);
        wait_run;
        wr(2'h0, 8'h05);
        for (int k = 0; k < 4; k++) begin
            core.exec(k[0] ? 2'h2 : 2'h1);
            watch(600, at);
            chk("alternate", {7'h0, at < 0}, 8'h01);
        end
        opt_paired_clear_i <= 1'b0;
    endtask
    task automatic t_sleep;
        idle_req_i <= 1'b1;
        core.exec(2'h3);
        #1 chk("powerdown", {6'h0, powerdown_flag_o, dog_expiry_flag_o}, 8'h02);
        // clock enable is registered, so it drops one cycle after the halt
        @(posedge clock_i);
        #1 chk("clk_stop", {7'h0, core_clock_en_o}, 8'h00);
        watch(1500, at);
        chk("core_src_stop", {7'h0, at < 0}, 8'h01);
        pin_low(1'b1);
        wait_run;
        opt_src_core_i <= 1'b0;
        opt_osc_src_i <= 2'h0;
        idle_req_i <= 1'b0;
        wr(2'h0, 8'h05);
        core.exec(2'h3);
        watch(2300, at);
        chk("wake", {5'h0, pc_sp_clear_o, core_reset_o, dog_expiry_flag_o}, 8'h05);
        // crystal source: 1024 cycles from the wake pulse to run
        for (at = 0; at < 2000 && run_o !== 1'b1; at++) begin
            @(posedge clock_i);
            #1;
        end
        chk("wake_delay", {7'h0, at == 1024}, 8'h01);
        wait_run;
        rd(2'h0, 8'h05);
    endtask
    task automatic t_supply;
        low_supply_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        low_supply_i <= 1'b0;
        #1 chk("glitch", {7'h0, core_reset_o}, 8'h00);
        repeat (2) @(posedge clock_i);
        low_supply_i <= 1'b1;
        repeat (40) @(posedge clock_i);
        low_supply_i <= 1'b0;
        #1 chk("low_supply", {7'h0, core_reset_o}, 8'h01);
        wait_run;
        // option off: a long low-supply level must be ignored
        opt_low_supply_en_i <= 1'b0;
        low_supply_i <= 1'b1;
        repeat (40) @(posedge clock_i);
        #1 chk("low_supply_off", {7'h0, core_reset_o}, 8'h00);
        low_supply_i <= 1'b0;
        opt_low_supply_en_i <= 1'b1;
    endtask
    initial begin
        {resetn_i, wr_i, rd_i, low_supply_i, idle_req_i} = 5'h00;
        {opt_dog_enable_i, opt_src_core_i, opt_low_supply_en_i} = 3'h7;
        {opt_paired_clear_i, opt_ext_reset_en_i, shared_port_bit_i} = 3'h1;
        {addr_i, wdata_i, opt_osc_src_i} = 12'h1;
        failures = 0;
        tests_run = 0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        wait_run;
        chk("ports", port_data_o & port_dir_o, 8'hff);
        rd(2'h0, 8'h7a);
        t_overflow;
        t_pin;
        t_disable;
        t_paired;
        t_sleep;
        t_supply;
        summarize;
    end
    initial begin
        repeat (40000) @(posedge clock_i);
        failures++;
        summarize;
    end
endmodule // testbench
bind wdr_top wdr_sva #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_sva (.clock_i, .resetn_i,
    .rd_i, .rdata_o, .halt_cmd_i, .shared_port_bit_i, .opt_ext_reset_en_i,
    .core_reset_o, .pc_sp_clear_o, .run_o, .dog_expiry_flag_o, .powerdown_flag_o,
    .port_data_o, .port_dir_o);
`default_nettype wire

// >>> tb/wdr_core_model.sv
// behavioural core issuing watchdog clear and halt commands
`default_nettype none
module wdr_core_model (
    input wire logic clock_i, // core clock
    input wire logic run_i, // core may execute
    output logic single_o, // single clear executed
    output logic half_a_o, // half clear a executed
    output logic half_b_o, // half clear b executed
    output logic halt_o // halt executed
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {single_o, half_a_o, half_b_o, halt_o} = 4'h0;
    // code 0 single, 1 half a, 2 half b, 3 halt; a stopped core waits
    task automatic exec(input logic [1:0] code);
        @(posedge clock_i);
        while (run_i !== 1'b1) @(posedge clock_i);
        single_o <= code == 2'h0;
        half_a_o <= code == 2'h1;
        half_b_o <= code == 2'h2;
        halt_o <= code == 2'h3;
        @(posedge clock_i);
        {single_o, half_a_o, half_b_o, halt_o} <= 4'h0;
    endtask
endmodule // wdr_core_model
`default_nettype wire

// >>> tb/wdr_sva.sv
// port assertions for the watchdog and reset control block
`default_nettype none
module wdr_sva #(
    parameter [31:0] RESET_DELAY_CYC = 32'd20
) (
    input wire logic clock_i, // core clock
    input wire logic resetn_i, // power-on reset, active low
    input wire logic rd_i, // read strobe
    input wire logic [7:0] rdata_o, // read data
    input wire logic halt_cmd_i, // halt executed
    input wire logic shared_port_bit_i, // reset pin, active low
    input wire logic opt_ext_reset_en_i, // pin reset option
    input wire logic core_reset_o, // full reset
    input wire logic pc_sp_clear_o, // pc and sp clear pulse
    input wire logic run_o, // core may execute
    input wire logic dog_expiry_flag_o, // expiry flag
    input wire logic powerdown_flag_o, // powerdown flag
    input wire logic [7:0] port_data_o, // port data
    input wire logic [7:0] port_dir_o // port direction
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] hold_cnt;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // length of the current full reset, for the delay check
    always_ff @(posedge clock_i or negedge resetn_i)
        if (!resetn_i) hold_cnt <= 32'h0;
        else hold_cnt <= core_reset_o ? hold_cnt + 32'h1 : 32'h0;
    sequence s_pin_low;
        run_o && opt_ext_reset_en_i && !shared_port_bit_i;
    endsequence
    sequence s_halt;
        run_o && halt_cmd_i;
    endsequence
    property p_read_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    property p_reset_ports;
        core_reset_o |-> port_data_o == 8'hff && port_dir_o == 8'hff && !run_o;
    endproperty
    property p_delay;
        $fell(core_reset_o) |-> hold_cnt >= RESET_DELAY_CYC - 32'd2;
    endproperty
    property p_run_after;
        $fell(core_reset_o) |-> ##[0:1] run_o;
    endproperty
    property p_pin_reset;
        s_pin_low |-> ##[1:3] core_reset_o;
    endproperty
    property p_wake_pulse;
        pc_sp_clear_o |=> !pc_sp_clear_o;
    endproperty
    property p_wake_flags;
        pc_sp_clear_o |-> dog_expiry_flag_o && powerdown_flag_o && !core_reset_o;
    endproperty
    property p_halt;
        s_halt |=> powerdown_flag_o && !dog_expiry_flag_o;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("rdata not zero");
    a_reset_ports: assert property (p_reset_ports) else $error("ports in reset");
    a_delay: assert property (p_delay) else $error("reset delay short");
    a_run_after: assert property (p_run_after) else $error("no run after reset");
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset missing");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse long");
    a_wake_flags: assert property (p_wake_flags) else $error("wake flags");
    a_halt: assert property (p_halt) else $error("halt flags");
endmodule // wdr_sva
`default_nettype wire
